// ==== core/pmc_map.vh ====
// Register map, field positions and reset values of the port match and crossbar control block
// Operation
// [RL1] Pullup-disable bit 7 clear enables weak pullups except on analog pins; the code also turns them off on push-pull pins and pins driving low.
// [RL2] Crossbar enable bit set enables crossbar; cleared, drivers off, pins are inputs.
// [RL3] Timer 1 and timer 0 inputs reach pins only with bits 5 and 4 set.
// [RL4] Counter input reaches a pin only when bit 3 is set.
// [RL5] Bit 2 of crossbar control two reads zero, writes are ignored.
// [RL6] Module pin field: 00 none, 01 module 0, 10 modules 0-1, 11 modules 0-2.
// [RL7] Mismatch when masked port 0 or port 1 pins differ from masked match value.
// [RL8] Mask bit 1 compares the pin; mask bit 0 excludes it from mismatch.
// [RL9] Match bit gives expected level: 0 low, 1 high.
// [RL10] Mismatch uses real pin levels regardless of crossbar routing.
// [RL11] Mismatch event is offered as interrupt source and idle/suspend wake-up source.
// [RL12] Port data registers are byte and bit accessible.
// [RL13] Port write stores an output latch that holds pin level until next write.
// [RL14] Ordinary port read returns pin levels, even for pins given to peripherals.
// [RL15] Read-modify-write accesses of a port read the latch, not the pins.
// [RL16] Two-wire bus data and clock pins are always open-drain.
// [RL17] Port 2 pin 4 is digital only; no analog input mode.
// [RL18] Pins pass a two-stage synchroniser before the mask-and-match compare.
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ***********************************************
// Register addresses
// ***********************************************
`define PMC_ADDR_PORT0_DATA        8'h80
`define PMC_ADDR_PORT1_DATA        8'h90
`define PMC_ADDR_XBAR_CTRL_TWO     8'hE2
`define PMC_ADDR_PORT1_MATCH       8'hED
`define PMC_ADDR_PORT1_MASK        8'hEE
`define PMC_ADDR_PORT0_MATCH       8'hFD
`define PMC_ADDR_PORT0_MASK        8'hFE

// ***********************************************
// Field positions of crossbar control two
// ***********************************************
`define PMC_BIT_PULLUP_DISABLE     7
`define PMC_BIT_CROSSBAR_ENABLE    6
`define PMC_BIT_TIMER1_ROUTE       5
`define PMC_BIT_TIMER0_ROUTE       4
`define PMC_BIT_COUNTER_ROUTE      3
`define PMC_BIT_UNUSED             2
`define PMC_FLD_PIN_SEL_HI         1
`define PMC_FLD_PIN_SEL_LO         0
`define PMC_XBAR_WRITE_MASK        8'hFB

// ***********************************************
// Reset values
// ***********************************************
`define PMC_RST_XBAR_CTRL_TWO      8'h00
`define PMC_RST_MATCH              8'hFF
`define PMC_RST_MASK               8'h00
`define PMC_RST_PORT_LATCH         8'hFF
`define PMC_RST_RDATA              8'h00

// ***********************************************
// Module pin select encodings
// ***********************************************
`define PMC_PINSEL_NONE            2'b00
`define PMC_PINSEL_M0              2'b01
`define PMC_PINSEL_M01             2'b10
`define PMC_PINSEL_M012            2'b11

`endif

// ==== core/pmc_port_ctrl.v ====
// Port data latches, crossbar control two, port match compare and pin drive control
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_port_ctrl (
  input  wire        i_clk,
  input  wire        i_rst,
  // Special-function-register bus
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_wdata,
  input  wire        i_sfr_wr,
  input  wire        i_sfr_rd,
  input  wire        i_sfr_rmw,
  input  wire        i_sfr_bit_wr,
  input  wire [2:0]  i_sfr_bit_sel,
  input  wire        i_sfr_bit_val,
  output reg  [7:0]  o_sfr_rdata,
  // Pin configuration from the mode registers held elsewhere
  input  wire [15:0] i_input_mode_select,
  input  wire [15:0] i_output_mode_select,
  input  wire [15:0] i_smb_pin,
  // Pads of ports 0 and 1
  input  wire [15:0] i_pin_in,
  output reg  [15:0] o_pin_out,
  output reg  [15:0] o_pin_oe,
  output reg  [15:0] o_pullup_en,
  // Port 2 pin 4 pad, digital only
  input  wire        i_p24_latch,
  input  wire        i_p24_push_pull,
  output reg         o_p24_out,
  output reg         o_p24_oe,
  output reg         o_p24_pullup_en,
  // Routing enables toward the crossbar decoder
  output reg         o_crossbar_enable,
  output reg         o_timer1_input_route,
  output reg         o_timer0_input_route,
  output reg         o_array_counter_input_route,
  output reg  [2:0]  o_compare_module_io_route,
  // Mismatch event
  input  wire        i_idle,
  input  wire        i_suspend,
  output reg         o_mismatch_irq,
  output reg         o_mismatch_wake
);

  // ***********************************************
  // Decode helpers
  // ***********************************************
  function [2:0] pmc_cex_route;
    input [1:0] sel;
    begin
      case (sel)
        `PMC_PINSEL_NONE: pmc_cex_route = 3'b000;
        `PMC_PINSEL_M0:   pmc_cex_route = 3'b001;
        `PMC_PINSEL_M01:  pmc_cex_route = 3'b011;
        `PMC_PINSEL_M012: pmc_cex_route = 3'b111;
        default:          pmc_cex_route = 3'b000;
      endcase
    end
  endfunction

  function pmc_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      pmc_hit = (addr == target);
    end
  endfunction

  function [7:0] pmc_set_bit;
    input [7:0] value;
    input [2:0] pos;
    input       bitv;
    reg   [7:0] onehot;
    begin
      onehot      = 8'h01 << pos;
      pmc_set_bit = bitv ? (value | onehot) : (value & ~onehot);
    end
  endfunction

  // ***********************************************
  // Registers
  // ***********************************************
  reg  [7:0]  xbar_ctrl_two_r;
  reg  [7:0]  port0_match_value_r;
  reg  [7:0]  port0_compare_mask_r;
  reg  [7:0]  port1_match_value_r;
  reg  [7:0]  port1_compare_mask_r;
  reg  [7:0]  port0_latch_r;
  reg  [7:0]  port1_latch_r;
  reg  [7:0]  rdata_nxt;
  wire [15:0] pin_sync;

  wire hit_p0    = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT0_DATA);
  wire hit_p1    = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT1_DATA);
  wire hit_xbar  = pmc_hit(i_sfr_addr, `PMC_ADDR_XBAR_CTRL_TWO);
  wire hit_port0_match_value = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT0_MATCH);
  wire hit_p0msk = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT0_MASK);
  wire hit_port1_match_value = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT1_MATCH);
  wire hit_p1msk = pmc_hit(i_sfr_addr, `PMC_ADDR_PORT1_MASK);

  wire pullup_disable  = xbar_ctrl_two_r[`PMC_BIT_PULLUP_DISABLE];
  wire crossbar_enable = xbar_ctrl_two_r[`PMC_BIT_CROSSBAR_ENABLE];
  wire [15:0] port_latch = {port1_latch_r, port0_latch_r};

  // ***********************************************
  // Pin synchroniser
  // ***********************************************
  // Metastability guard ahead of both the compare and port reads
  pmc_sync2 #(
    .W (16)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pin_in),
    .o_sync  (pin_sync)  // [RL18]
  );

  // ***********************************************
  // Register writes
  // ***********************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xbar_ctrl_two_r      <= `PMC_RST_XBAR_CTRL_TWO;
      port0_match_value_r  <= `PMC_RST_MATCH;
      port0_compare_mask_r <= `PMC_RST_MASK;
      port1_match_value_r  <= `PMC_RST_MATCH;
      port1_compare_mask_r <= `PMC_RST_MASK;
      port0_latch_r        <= `PMC_RST_PORT_LATCH;
      port1_latch_r        <= `PMC_RST_PORT_LATCH;
    end else begin
      if (i_sfr_wr) begin
        if (hit_xbar) begin
          xbar_ctrl_two_r <= i_sfr_wdata & `PMC_XBAR_WRITE_MASK;  // [RL5]
        end
        if (hit_port0_match_value) begin
          port0_match_value_r <= i_sfr_wdata;
        end
        if (hit_p0msk) begin
          port0_compare_mask_r <= i_sfr_wdata;
        end
        if (hit_port1_match_value) begin
          port1_match_value_r <= i_sfr_wdata;
        end
        if (hit_p1msk) begin
          port1_compare_mask_r <= i_sfr_wdata;
        end
        if (hit_p0) begin
          port0_latch_r <= i_sfr_wdata;  // [RL13]
        end
        if (hit_p1) begin
          port1_latch_r <= i_sfr_wdata;  // [RL13]
        end
      end else if (i_sfr_bit_wr) begin
        // Single-bit writes touch only the addressed latch bit
        if (hit_p0) begin
          port0_latch_r <= pmc_set_bit(port0_latch_r, i_sfr_bit_sel, i_sfr_bit_val);  // [RL12]
        end
        if (hit_p1) begin
          port1_latch_r <= pmc_set_bit(port1_latch_r, i_sfr_bit_sel, i_sfr_bit_val);  // [RL12]
        end
      end
    end
  end

  // ***********************************************
  // Register reads
  // ***********************************************
  always @* begin
    rdata_nxt = `PMC_RST_RDATA;
    if (hit_xbar) begin
      rdata_nxt = xbar_ctrl_two_r & `PMC_XBAR_WRITE_MASK;  // [RL5]
    end else if (hit_port0_match_value) begin
      rdata_nxt = port0_match_value_r;
    end else if (hit_p0msk) begin
      rdata_nxt = port0_compare_mask_r;
    end else if (hit_port1_match_value) begin
      rdata_nxt = port1_match_value_r;
    end else if (hit_p1msk) begin
      rdata_nxt = port1_compare_mask_r;
    end else if (hit_p0) begin
      rdata_nxt = i_sfr_rmw ? port0_latch_r : pin_sync[7:0];  // [RL14] [RL15]
    end else if (hit_p1) begin
      rdata_nxt = i_sfr_rmw ? port1_latch_r : pin_sync[15:8];  // [RL14] [RL15]
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= `PMC_RST_RDATA;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata_nxt;
    end
  end

  // ***********************************************
  // Pin drive and weak pullups
  // ***********************************************
  wire [15:0] pin_out_nxt;
  wire [15:0] pin_oe_nxt;
  wire [15:0] pullup_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
      wire digital   = i_input_mode_select[gi];
      // Two-wire bus pins never drive high, whatever the mode bit says
      wire push_pull = i_output_mode_select[gi] & ~i_smb_pin[gi];  // [RL16]
      wire drive_low = crossbar_enable & digital & ~port_latch[gi];
      assign pin_oe_nxt[gi]  = crossbar_enable & digital & (push_pull | ~port_latch[gi]);  // [RL2]
      assign pin_out_nxt[gi] = push_pull & port_latch[gi];
      // Pullup off while driving low saves static current
      assign pullup_nxt[gi]  = ~pullup_disable & digital & ~push_pull & ~drive_low;  // [RL1]
    end
  endgenerate

  // No analog mode exists for this pin, so no input-mode gate
  wire p24_oe_nxt     = crossbar_enable & (i_p24_push_pull | ~i_p24_latch);  // [RL17]
  wire p24_out_nxt    = i_p24_push_pull & i_p24_latch;
  wire p24_pullup_nxt = ~pullup_disable & ~i_p24_push_pull & ~(crossbar_enable & ~i_p24_latch);  // [RL17]

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out       <= 16'h0000;
      o_pin_oe        <= 16'h0000;
      o_pullup_en     <= 16'h0000;
      o_p24_out       <= 1'b0;
      o_p24_oe        <= 1'b0;
      o_p24_pullup_en <= 1'b0;
    end else begin
      o_pin_out       <= pin_out_nxt;
      o_pin_oe        <= pin_oe_nxt;
      o_pullup_en     <= pullup_nxt;
      o_p24_out       <= p24_out_nxt;
      o_p24_oe        <= p24_oe_nxt;
      o_p24_pullup_en <= p24_pullup_nxt;
    end
  end

  // ***********************************************
  // Peripheral routing enables
  // ***********************************************
  // Routing only counts once the crossbar itself is on
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crossbar_enable           <= 1'b0;
      o_timer1_input_route        <= 1'b0;
      o_timer0_input_route        <= 1'b0;
      o_array_counter_input_route <= 1'b0;
      o_compare_module_io_route   <= 3'b000;
    end else begin
      o_crossbar_enable           <= crossbar_enable;  // [RL2]
      o_timer1_input_route        <= crossbar_enable & xbar_ctrl_two_r[`PMC_BIT_TIMER1_ROUTE];  // [RL3]
      o_timer0_input_route        <= crossbar_enable & xbar_ctrl_two_r[`PMC_BIT_TIMER0_ROUTE];  // [RL3]
      o_array_counter_input_route <= crossbar_enable & xbar_ctrl_two_r[`PMC_BIT_COUNTER_ROUTE];  // [RL4]
      o_compare_module_io_route   <= {3{crossbar_enable}} &
                                     pmc_cex_route(xbar_ctrl_two_r[`PMC_FLD_PIN_SEL_HI:`PMC_FLD_PIN_SEL_LO]);  // [RL6]
    end
  end

  // ***********************************************
  // Port match compare
  // ***********************************************
  // Raw synchronised pins, not the routed view of the crossbar
  wire [7:0] p0_diff = (pin_sync[7:0] ^ port0_match_value_r) & port0_compare_mask_r;   // [RL8] [RL9] [RL10]
  wire [7:0] p1_diff = (pin_sync[15:8] ^ port1_match_value_r) & port1_compare_mask_r;  // [RL8] [RL9] [RL10]
  wire       mismatch_nxt = (|p0_diff) | (|p1_diff);  // [RL7]

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mismatch_irq  <= 1'b0;
      o_mismatch_wake <= 1'b0;
    end else begin
      o_mismatch_irq  <= mismatch_nxt;  // [RL11]
      o_mismatch_wake <= mismatch_nxt & (i_idle | i_suspend);  // [RL11]
    end
  end

endmodule // pmc_port_ctrl

// ==== core/pmc_sync2.v ====
// Two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module pmc_sync2 #(
  parameter W = 16
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage is read only by the second
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // pmc_sync2

// ==== test/pmc_pad_model.sv ====
// Pad model of ports 0 and 1: resolves each pin from all drivers
`timescale 1ns/1ps
module pmc_pad_model (
  input  wire        i_clk,
  input  wire [15:0] i_out,
  input  wire [15:0] i_oe,
  input  wire [15:0] i_pullup,
  input  wire [15:0] i_ext_en,
  input  wire [15:0] i_ext_val,
  output wire [15:0] o_level
);
  logic [15:0] last_r = 16'h0000;
  // Undriven pin without pullup shows the inverse of its last level, never a stable guess
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                 | (~i_oe & ~i_ext_en & (i_pullup | ~last_r));
  always @(posedge i_clk) begin
    last_r <= o_level;
  end
endmodule // pmc_pad_model

// ==== test/pmc_port_ctrl_checker.sv ====
// Port-level assertions of the port match and crossbar control block
`timescale 1ns/1ps
module pmc_port_ctrl_checker (
  input wire        i_clk,
  input wire        i_rst,
  input wire [7:0]  i_sfr_addr,
  input wire        i_sfr_rd,
  input wire [15:0] i_input_mode_select,
  input wire [15:0] i_smb_pin,
  input wire        i_p24_push_pull,
  input wire        i_idle,
  input wire        i_suspend,
  input wire [7:0]  o_sfr_rdata,
  input wire [15:0] o_pin_out,
  input wire [15:0] o_pin_oe,
  input wire [15:0] o_pullup_en,
  input wire        o_p24_pullup_en,
  input wire        o_crossbar_enable,
  input wire        o_timer1_input_route,
  input wire        o_timer0_input_route,
  input wire        o_array_counter_input_route,
  input wire [2:0]  o_compare_module_io_route,
  input wire        o_mismatch_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ***********************************************
  // Sequences
  // ***********************************************
  sequence s_rd_unmapped;
    i_sfr_rd && !(i_sfr_addr inside {8'h80, 8'h90, 8'hE2, 8'hED, 8'hEE, 8'hFD, 8'hFE});
  endsequence
  sequence s_rd_ctrl;
    i_sfr_rd && i_sfr_addr == 8'hE2;
  endsequence
  // ***********************************************
  // Assertions
  // ***********************************************
  unmapped_read_a: assert property (s_rd_unmapped |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  unused_bit_a: assert property (s_rd_ctrl |=> !o_sfr_rdata[2])
    else $error("unused bit reads one");
  route_gate_a: assert property ((o_timer1_input_route | o_timer0_input_route) |-> o_crossbar_enable)
    else $error("timer route without crossbar");
  counter_gate_a: assert property (o_array_counter_input_route |-> o_crossbar_enable)
    else $error("counter route without crossbar");
  module_route_a: assert property (o_compare_module_io_route inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("illegal module route set");
  drivers_off_a: assert property (!o_crossbar_enable |-> o_pin_oe == 16'h0000)
    else $error("driver on with crossbar off");
  pullup_pushpull_a: assert property ((o_pullup_en & o_pin_out) == 16'h0000)
    else $error("pullup on push-pull high pin");
  smb_open_drain_a: assert property (##1 (o_pin_out & $past(i_smb_pin)) == 16'h0000)
    else $error("two-wire pin driven high");
  analog_pin_a: assert property (##1 ((o_pin_oe | o_pullup_en) & ~$past(i_input_mode_select)) == 16'h0000)
    else $error("analog pin driven or pulled");
  p24_pullup_a: assert property (##1 (o_p24_pullup_en |-> !$past(i_p24_push_pull)))
    else $error("pin 2.4 pullup in push-pull");
  wake_mode_a: assert property (##1 (o_mismatch_wake |-> $past(i_idle | i_suspend)))
    else $error("wake outside low power");
endmodule // pmc_port_ctrl_checker

// ==== test/pmc_port_ctrl_test.sv ====
// Self-checking testbench of the port match and crossbar control block
`timescale 1ns/1ps
module pmc_port_ctrl_test;
  logic i_clk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_sfr_rmw = 0, i_sfr_bit_wr = 0;
  logic i_sfr_bit_val = 0, i_p24_latch = 1, i_p24_push_pull = 0, i_idle = 0, i_suspend = 0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  logic [2:0] i_sfr_bit_sel = 3'h0;
  logic [15:0] i_input_mode_select = 16'hFFFF, i_output_mode_select = 16'h0000, i_smb_pin = 16'h0000;
  logic [15:0] ext_en = 16'h0000, ext_v = 16'h0000;
  wire [15:0] i_pin_in, o_pin_out, o_pin_oe, o_pullup_en;
  wire [7:0] o_sfr_rdata;
  wire [2:0] o_compare_module_io_route;
  wire o_p24_out, o_p24_oe, o_p24_pullup_en, o_crossbar_enable, o_timer1_input_route;
  wire o_timer0_input_route, o_array_counter_input_route, o_mismatch_irq, o_mismatch_wake;
  int n_mismatch = 0, checks = 0;
  pmc_port_ctrl u_dut (.*);
  pmc_pad_model u_pad (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pullup(o_pullup_en),
                       .i_ext_en(ext_en), .i_ext_val(ext_v), .o_level(i_pin_in));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // ***********************************************
  // Bus tasks
  // ***********************************************
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
    @(posedge i_clk);
    #1 i_sfr_wr = 0;
  endtask
  task bw(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(posedge i_clk);
    #1 {i_sfr_bit_wr, i_sfr_addr, i_sfr_bit_sel, i_sfr_bit_val} = {1'b1, a, s, v};
    @(posedge i_clk);
    #1 i_sfr_bit_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge i_clk);
    #1 {i_sfr_rd, i_sfr_addr, i_sfr_rmw} = {1'b1, a, m};
    @(posedge i_clk);
    #1 {i_sfr_rd, i_sfr_rmw} = 2'b00;
    chk({8'h00, o_sfr_rdata}, {8'h00, e});
  endtask
  task pause;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  // ***********************************************
  // Scenarios
  // ***********************************************
  task t_reset;
    // Outputs leave their reset values only at the first edge after release
    @(posedge i_clk);
    #1;
    chk(o_pullup_en, 16'hFFFF);
    rd(8'hE2, 0, 8'h00);
    rd(8'hED, 0, 8'hFF);
    rd(8'hEE, 0, 8'h00);
    rd(8'hFD, 0, 8'hFF);
    rd(8'hFE, 0, 8'h00);
    rd(8'h81, 0, 8'h00);
    rd(8'h90, 1, 8'hFF);
  endtask
  task t_ctrl;
    logic [2:0] tbl [4];
    tbl = '{3'h0, 3'h1, 3'h3, 3'h7};
    wr(8'hE2, 8'hFF);
    rd(8'hE2, 0, 8'hFB);
    chk({o_crossbar_enable, o_timer1_input_route,
         o_timer0_input_route, o_array_counter_input_route}, 4'hF);
    chk(o_pullup_en, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(8'hE2, 8'h40 | c[7:0]);
      // Routes are registered one edge after the control write lands
      pause;
      chk({13'h0, o_compare_module_io_route}, {13'h0, tbl[c]});
      chk({o_timer1_input_route, o_timer0_input_route, o_array_counter_input_route}, 3'h0);
    end
  endtask
  task t_match;
    {ext_en, ext_v} = {16'hFFFF, 16'h0005};
    wr(8'hFE, 8'h0F);
    wr(8'hFD, 8'h05);
    wr(8'hEE, 8'h80);
    wr(8'hED, 8'h00);
    pause;
    chk(o_mismatch_irq, 0);
    ext_v = 16'h0015;
    pause;
    chk(o_mismatch_irq, 0);
    ext_v = 16'h0007;
    pause;
    chk({o_mismatch_irq, o_mismatch_wake}, 2'b10);
    i_idle = 1;
    pause;
    chk(o_mismatch_wake, 1);
    {i_idle, i_suspend} = 2'b01;
    pause;
    chk(o_mismatch_wake, 1);
    {i_suspend, ext_v} = {1'b0, 16'h8005};
    pause;
    chk(o_mismatch_irq, 1);
    wr(8'hEE, 8'h00);
    wr(8'hFE, 8'h00);
    pause;
    chk(o_mismatch_irq, 0);
  endtask
  task t_port;
    ext_en = 16'h0000;
    wr(8'h80, 8'h3C);
    pause;
    rd(8'h80, 0, 8'h3C);
    chk(o_pin_oe, 16'h00C3);
    {ext_en, ext_v} = {16'h00FF, 16'h0000};
    pause;
    rd(8'h80, 0, 8'h00);
    rd(8'h80, 1, 8'h3C);
    bw(8'h80, 3'h0, 1);
    rd(8'h80, 1, 8'h3D);
    {i_output_mode_select, i_smb_pin, i_input_mode_select} = {16'h00FF, 16'h0001, 16'hFFFD};
    {i_p24_latch, i_p24_push_pull} = 2'b00;
    pause;
    chk({o_pin_out[7:0], o_pin_oe[7:0]}, 16'h3CFC);
    chk(o_pullup_en, 16'hFF01);
    chk({o_p24_out, o_p24_oe, o_p24_pullup_en}, 3'b010);
    {i_p24_latch, i_p24_push_pull} = 2'b11;
    pause;
    chk({o_p24_out, o_p24_oe, o_p24_pullup_en}, 3'b110);
    wr(8'hE2, 8'h00);
    pause;
    chk(o_pin_oe, 16'h0000);
    chk({15'h0000, o_p24_oe}, 16'h0000);
  endtask
  task wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    #1 i_rst = 0;
    t_reset;
    t_ctrl;
    t_match;
    t_port;
    wrap_up;
  end
  // Whole run is under 150 cycles; generous margin before calling it hung
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
endmodule // pmc_port_ctrl_test
bind pmc_port_ctrl pmc_port_ctrl_checker u_chk (.i_clk, .i_rst, .i_sfr_addr, .i_sfr_rd, .i_input_mode_select,
  .i_smb_pin, .i_p24_push_pull, .i_idle, .i_suspend, .o_sfr_rdata, .o_pin_out, .o_pin_oe, .o_pullup_en,
  .o_p24_pullup_en, .o_crossbar_enable, .o_timer1_input_route, .o_timer0_input_route,
  .o_array_counter_input_route, .o_compare_module_io_route, .o_mismatch_wake);
